/* File: inc/ddc_pkg.sv */
package ddc_pkg;
    // ------------------------------------------------------------
    // Register offsets (seven-bit serial address space)
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_INT = 7'h00;
    localparam logic [6:0] ADDR_STATUS = 7'h01;
    localparam logic [6:0] ADDR_LINE_CFG = 7'h04;
    localparam logic [6:0] ADDR_AUX_CFG = 7'h05;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_LEVEL_BIT = 2;
    localparam int CFG_TRACK_BIT = 3;
    localparam int ST_LINE_FAULT = 0;
    localparam int ST_AUX_FAULT = 1;
    localparam int ST_SERIAL = 2;
    localparam int ST_TRACK = 3;
    localparam int CMD_WRITE_BIT = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_CFG_RST = 8'h03;
    localparam logic [7:0] AUX_CFG_RST = 8'h03;
    // ------------------------------------------------------------
    // Host Wishbone map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] WB_CMD = 4'h0;
    localparam logic [3:0] WB_STAT = 4'h4;
    localparam logic [3:0] WB_PINS = 4'h8;
    localparam logic [6:0] PINS_RST = 7'h00;
    // ------------------------------------------------------------
    // Timing: half period of host serial clock
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int SCK_HALF_NS = 80;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS = 16;

    typedef enum logic [1:0] {
        DDC_SINK, DDC_SOURCE, DDC_PUSHPULL, DDC_OFF
    } ddc_type_t;
endpackage

/* File: inc/ddc_link_if.sv */
`timescale 1ns/1ps
interface ddc_link_if;
    logic mode_sel;
    logic csn_pp;
    logic sdi_sink;
    logic sck;
    logic sdo;
    logic sdo_oe_n;
    logic sdo_line;
    logic line_enable_pin;
    logic line_transmit_pin;
    logic aux_enable_pin;
    logic aux_transmit_pin;

    // Open-drain style pull-up when released
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

    modport dev (
        input mode_sel, csn_pp, sdi_sink, sck,
        input line_enable_pin, line_transmit_pin,
        input aux_enable_pin, aux_transmit_pin,
        output sdo, sdo_oe_n
    );
    modport host (
        output mode_sel, csn_pp, sdi_sink, sck,
        output line_enable_pin, line_transmit_pin,
        output aux_enable_pin, aux_transmit_pin,
        input sdo_line
    );
endinterface

/* File: rtl/ddc_drv_decode.sv */
`timescale 1ns/1ps
module ddc_drv_decode (
    // Control
    input wire logic serial_i,
    input wire logic en_i,
    input wire logic tx_i,
    input wire logic level_i,
    input wire ddc_pkg::ddc_type_t type_i,
    input wire logic fault_i,
    // Drive
    output logic hi_o,
    output logic lo_o
);
    logic want_hi;
    logic want_lo;
    logic can_hi;
    logic can_lo;

    always_comb begin
        can_hi = (type_i == ddc_pkg::DDC_SOURCE) ||
                 (type_i == ddc_pkg::DDC_PUSHPULL);
        can_lo = (type_i == ddc_pkg::DDC_SINK) ||
                 (type_i == ddc_pkg::DDC_PUSHPULL);
        want_hi = 1'b0;
        want_lo = 1'b0;
        if (!serial_i) begin
            want_hi = en_i && !tx_i;
            want_lo = en_i && tx_i;
        end else if (type_i != ddc_pkg::DDC_OFF) begin
            want_hi = level_i || (en_i && !tx_i);
            want_lo = !level_i && en_i && tx_i;
        end
        hi_o = want_hi && can_hi && !fault_i;
        lo_o = want_lo && can_lo && !fault_i;
    end
endmodule

/* File: rtl/ddc_device.sv */
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// - Select pin low pin mode, high serial
// - Pin mode main driver enable/transmit decode
// - Pin mode auxiliary driver same decode
// - Serial main driver: type, level, pins
// - Serial auxiliary driver, same decode
// - Pin mode types from two shared pins
// - Tracking: auxiliary adopts main configuration
// - Tracking serial only, main pins drive
// - Tracking ignores auxiliary enable/transmit pins
// - Tracking: any fault turns off both
// - Fault flags only for faulty driver
// - Host disables drivers before reconfiguring
// - First byte: seven-bit address, write bit
// - Status byte shifted out first
// - Then the addressed data byte
// - Host uses mode zero, clock idle low
// - Sample serial input on rising clock
// - Update serial output on falling clock
// - Transfers only while select held low
// - Interrupt bits sticky, cleared on read
module ddc_device (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Link
    ddc_link_if.dev link,
    // Fault sense from each driver
    input wire logic line_fault_i,
    input wire logic aux_fault_i,
    // Driver controls
    output logic line_hi_o,
    output logic line_lo_o,
    output logic aux_hi_o,
    output logic aux_lo_o,
    output logic serial_mode_o
);
    localparam int NS = 8;

    logic [NS-1:0] meta_reg;
    logic [NS-1:0] sync_reg;
    logic sck_d_reg;
    logic csn_d_reg;
    logic [2:0] bit_cnt_reg;
    logic first_reg;
    logic write_reg;
    logic [6:0] addr_reg;
    logic [6:0] in_reg;
    logic [7:0] out_reg;
    logic [7:0] out_next_reg;
    logic [7:0] int_reg;
    logic [7:0] line_cfg_reg;
    logic [7:0] aux_cfg_reg;
    logic sdo_reg;
    logic sdo_oe_n_reg;
    logic line_hi_reg;
    logic line_lo_reg;
    logic aux_hi_reg;
    logic aux_lo_reg;

    logic serial;
    logic csn;
    logic sck;
    logic sdi;
    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic [7:0] byte_in;
    logic [6:0] rd_addr;
    logic rd_int;
    logic tracking;
    logic any_fault;
    logic [7:0] status;
    logic [7:0] int_set;
    ddc_pkg::ddc_type_t line_type;
    ddc_pkg::ddc_type_t aux_type;
    logic aux_en;
    logic aux_tx;
    logic aux_level;
    logic line_kill;
    logic aux_kill;
    logic line_hi;
    logic line_lo;
    logic aux_hi;
    logic aux_lo;

    function automatic logic [7:0] reg_read(
        input logic [6:0] a,
        input logic [7:0] st,
        input logic [7:0] ir,
        input logic [7:0] lc,
        input logic [7:0] ac
    );
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ddc_pkg::ADDR_INT: d = ir;
            ddc_pkg::ADDR_STATUS: d = st;
            ddc_pkg::ADDR_LINE_CFG: d = lc;
            ddc_pkg::ADDR_AUX_CFG: d = ac;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {link.mode_sel, link.csn_pp, link.sdi_sink,
                         link.sck, link.line_enable_pin,
                         link.line_transmit_pin, link.aux_enable_pin,
                         link.aux_transmit_pin};
            sync_reg <= meta_reg;
        end
    end

    assign serial = sync_reg[7];
    assign csn = sync_reg[6];
    assign sdi = sync_reg[5];
    assign sck = sync_reg[4];

    // ------------------------------------------------------------
    // Driver decode
    // ------------------------------------------------------------
    always_comb begin
        tracking = serial && aux_cfg_reg[ddc_pkg::CFG_TRACK_BIT];
        any_fault = line_fault_i || aux_fault_i;
        if (!serial) begin
            // Pin mode: both drivers share one type
            if (csn) begin
                line_type = ddc_pkg::DDC_PUSHPULL;
            end else if (sdi) begin
                line_type = ddc_pkg::DDC_SINK;
            end else begin
                line_type = ddc_pkg::DDC_SOURCE;
            end
            aux_type = line_type;
        end else begin
            line_type = ddc_pkg::ddc_type_t'(line_cfg_reg[1:0]);
            aux_type = ddc_pkg::ddc_type_t'(aux_cfg_reg[1:0]);
        end
        aux_en = sync_reg[1];
        aux_tx = sync_reg[0];
        aux_level = aux_cfg_reg[ddc_pkg::CFG_LEVEL_BIT];
        line_kill = line_fault_i;
        aux_kill = aux_fault_i;
        if (tracking) begin
            aux_type = line_type;
            aux_level = line_cfg_reg[ddc_pkg::CFG_LEVEL_BIT];
            aux_en = sync_reg[3];
            aux_tx = sync_reg[2];
            line_kill = any_fault;
            aux_kill = any_fault;
        end
    end

    ddc_drv_decode u_line (
        .serial_i(serial),
        .en_i(sync_reg[3]),
        .tx_i(sync_reg[2]),
        .level_i(line_cfg_reg[ddc_pkg::CFG_LEVEL_BIT]),
        .type_i(line_type),
        .fault_i(line_kill),
        .hi_o(line_hi),
        .lo_o(line_lo)
    );

    ddc_drv_decode u_aux (
        .serial_i(serial),
        .en_i(aux_en),
        .tx_i(aux_tx),
        .level_i(aux_level),
        .type_i(aux_type),
        .fault_i(aux_kill),
        .hi_o(aux_hi),
        .lo_o(aux_lo)
    );

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_hi_reg <= 1'b0;
            line_lo_reg <= 1'b0;
            aux_hi_reg <= 1'b0;
            aux_lo_reg <= 1'b0;
        end else begin
            line_hi_reg <= line_hi;
            line_lo_reg <= line_lo;
            aux_hi_reg <= aux_hi;
            aux_lo_reg <= aux_lo;
        end
    end

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    assign sck_rise = sck && !sck_d_reg;
    assign sck_fall = !sck && sck_d_reg;
    assign byte_done = serial && !csn && sck_rise && (bit_cnt_reg == 3'd7);
    assign byte_in = {in_reg, sdi};
    assign rd_addr = first_reg ? byte_in[6:0] : addr_reg + 7'd1;
    assign rd_int = byte_done && (rd_addr == ddc_pkg::ADDR_INT) &&
                    !(first_reg ? byte_in[ddc_pkg::CMD_WRITE_BIT] :
                      write_reg);

    always_comb begin
        status = 8'h00;
        status[ddc_pkg::ST_LINE_FAULT] = line_fault_i;
        status[ddc_pkg::ST_AUX_FAULT] = aux_fault_i;
        status[ddc_pkg::ST_SERIAL] = serial;
        status[ddc_pkg::ST_TRACK] = tracking;
        // Only the driver at fault flags itself
        int_set = 8'h00;
        int_set[ddc_pkg::ST_LINE_FAULT] = line_fault_i;
        int_set[ddc_pkg::ST_AUX_FAULT] = aux_fault_i;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_d_reg <= 1'b0;
            csn_d_reg <= 1'b1;
            bit_cnt_reg <= 3'd0;
            first_reg <= 1'b1;
            write_reg <= 1'b0;
            addr_reg <= 7'h00;
            in_reg <= 7'h00;
            out_next_reg <= 8'h00;
        end else begin
            sck_d_reg <= sck;
            csn_d_reg <= csn;
            if (!serial || csn) begin
                bit_cnt_reg <= 3'd0;
                first_reg <= 1'b1;
            end else if (sck_rise) begin
                in_reg <= byte_in[6:0];
                bit_cnt_reg <= bit_cnt_reg + 3'd1;
                if (bit_cnt_reg == 3'd7) begin
                    first_reg <= 1'b0;
                    addr_reg <= rd_addr;
                    if (first_reg) begin
                        write_reg <= byte_in[ddc_pkg::CMD_WRITE_BIT];
                    end
                    out_next_reg <= reg_read(rd_addr, status, int_reg,
                                             line_cfg_reg, aux_cfg_reg);
                end
            end
        end
    end

    // Writes land on the byte's last rising edge
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_cfg_reg <= ddc_pkg::LINE_CFG_RST;
            aux_cfg_reg <= ddc_pkg::AUX_CFG_RST;
        end else if (byte_done && !first_reg && write_reg) begin
            if (addr_reg == ddc_pkg::ADDR_LINE_CFG) begin
                line_cfg_reg <= byte_in;
            end
            if (addr_reg == ddc_pkg::ADDR_AUX_CFG) begin
                aux_cfg_reg <= byte_in;
            end
        end
    end

    // Set beats clear so no event slips past a read
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_reg <= 8'h00;
        end else begin
            int_reg <= (int_reg & ~{8{rd_int}}) | int_set;
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg <= 8'h00;
            sdo_reg <= 1'b1;
            sdo_oe_n_reg <= 1'b1;
        end else if (!serial) begin
            // Pin mode: shared pin reports auxiliary fault, low active
            sdo_reg <= 1'b0;
            sdo_oe_n_reg <= !aux_fault_i;
        end else if (csn) begin
            sdo_oe_n_reg <= 1'b1;
            sdo_reg <= 1'b1;
        end else if (csn_d_reg) begin
            out_reg <= status;
            sdo_reg <= status[7];
            sdo_oe_n_reg <= 1'b0;
        end else if (sck_fall) begin
            if (bit_cnt_reg == 3'd0) begin
                out_reg <= out_next_reg;
                sdo_reg <= out_next_reg[7];
            end else begin
                out_reg <= {out_reg[6:0], 1'b0};
                sdo_reg <= out_reg[6];
            end
        end
    end

    assign link.sdo = sdo_reg;
    assign link.sdo_oe_n = sdo_oe_n_reg;
    assign line_hi_o = line_hi_reg;
    assign line_lo_o = line_lo_reg;
    assign aux_hi_o = aux_hi_reg;
    assign aux_lo_o = aux_lo_reg;
    assign serial_mode_o = sync_reg[7];
endmodule

/* File: rtl/ddc_host.sv */
`timescale 1ns/1ps
module ddc_host #(
    parameter int HALF = ddc_pkg::SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link
    ddc_link_if.host link
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL} ddc_hst_t;

    ddc_hst_t state_reg;
    logic [7:0] cnt_reg;
    logic [4:0] bits_reg;
    logic [15:0] tx_reg;
    logic [15:0] rx_reg;
    logic [6:0] pins_reg;
    logic busy_reg;
    logic csn_reg;
    logic sck_reg;
    logic sdi_reg;
    logic [31:0] dat_reg;
    logic ack_reg;
    logic sdo_meta_reg;
    logic sdo_sync_reg;
    logic acc;
    logic start;

    assign acc = wb_cyc_i && wb_stb_i && !ack_reg;
    assign start = acc && wb_we_i && (wb_adr_i == ddc_pkg::WB_CMD) &&
                   wb_sel_i[0] && wb_sel_i[1] && !busy_reg &&
                   pins_reg[0];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            pins_reg <= ddc_pkg::PINS_RST;
        end else begin
            ack_reg <= acc;
            if (acc && wb_we_i && wb_adr_i == ddc_pkg::WB_PINS &&
                wb_sel_i[0]) begin
                pins_reg <= wb_dat_i[6:0];
            end
            if (acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    ddc_pkg::WB_STAT: dat_reg <= {8'h00, rx_reg, 7'h00,
                                                  busy_reg};
                    ddc_pkg::WB_PINS: dat_reg <= {25'h0, pins_reg};
                    default: dat_reg <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Serial engine, mode zero, MSB first
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sdo_meta_reg <= 1'b1;
            sdo_sync_reg <= 1'b1;
        end else begin
            sdo_meta_reg <= link.sdo_line;
            sdo_sync_reg <= sdo_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
            bits_reg <= 5'h00;
            tx_reg <= 16'h0;
            rx_reg <= 16'h0;
            busy_reg <= 1'b0;
            csn_reg <= 1'b1;
            sck_reg <= 1'b0;
            sdi_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        tx_reg <= {wb_dat_i[7:0], wb_dat_i[15:8]};
                        sdi_reg <= wb_dat_i[7];
                        csn_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        bits_reg <= 5'h00;
                        cnt_reg <= 8'(HALF);
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (cnt_reg == 8'h01) begin
                        sck_reg <= 1'b1;
                        rx_reg <= {rx_reg[14:0], sdo_sync_reg};
                        cnt_reg <= 8'(HALF);
                        state_reg <= ST_HIGH;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (cnt_reg == 8'h01) begin
                        sck_reg <= 1'b0;
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        sdi_reg <= tx_reg[14];
                        bits_reg <= bits_reg + 5'h01;
                        cnt_reg <= 8'(HALF);
                        state_reg <= (bits_reg == 5'(ddc_pkg::FRAME_BITS - 1))
                                     ? ST_TAIL : ST_LOW;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_TAIL: begin
                    if (cnt_reg == 8'h01) begin
                        csn_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    // With pins bit 0 low (pin mode), shared pins carry the pin-mode settings
    assign link.mode_sel = pins_reg[0];
    assign link.csn_pp = pins_reg[0] ? csn_reg : pins_reg[5];
    assign link.sdi_sink = pins_reg[0] ? sdi_reg : pins_reg[6];
    assign link.sck = sck_reg;
    assign link.line_enable_pin = pins_reg[1];
    assign link.line_transmit_pin = pins_reg[2];
    assign link.aux_enable_pin = pins_reg[3];
    assign link.aux_transmit_pin = pins_reg[4];
    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
endmodule

/* File: verification/ddc_link_properties.sv */
`timescale 1ns/1ps
module ddc_link_properties (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Link wires
    input wire logic mode_sel,
    input wire logic csn_pp,
    input wire logic sdi_sink,
    input wire logic sck,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic sck_reg;
    logic [5:0] rise_reg;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // ------------
    // Edge counting
    // ------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_reg <= 1'b0;
            rise_reg <= 6'h00;
        end else begin
            sck_reg <= sck;
            if (csn_pp) begin
                rise_reg <= 6'h00;
            end else if (sck && !sck_reg) begin
                rise_reg <= rise_reg + 6'h01;
            end
        end
    end
    // Mode switch also moves the shared select pin, so not a frame edge
    sequence frame_open;
        mode_sel && $past(mode_sel) && $fell(csn_pp);
    endsequence
    sequence frame_close;
        mode_sel && $past(mode_sel) && $rose(csn_pp);
    endsequence
    // Sync delay of the device allows a few cycles here
    sdo_drive_a: assert property (
        frame_open |-> ##[1:5] !sdo_oe_n)
        else $error("serial out not driven after select");
    sdo_release_a: assert property (
        frame_close |-> ##[1:5] sdo_oe_n)
        else $error("serial out not released");
    sck_lead_a: assert property (frame_open |-> !sck [*4])
        else $error("clock rose too early");
    sck_idle_a: assert property (mode_sel && csn_pp |-> !sck)
        else $error("clock not idle low");
    sdi_hold_a: assert property (
        mode_sel && !csn_pp && sck && sck_reg |-> $stable(sdi_sink))
        else $error("serial in moved while clock high");
    sdo_hold_a: assert property (
        mode_sel && !csn_pp && sck && sck_reg |-> $stable(sdo))
        else $error("serial out moved while clock high");
    bit_count_a: assert property (
        frame_close |-> rise_reg == 6'h10)
        else $error("frame length wrong");
    pin_flag_a: assert property (
        !mode_sel && !$past(mode_sel, 4) && !sdo_oe_n |-> !sdo)
        else $error("fault pin driven high");
endmodule

/* File: verification/dual_driver_control_spi_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module dual_driver_control_spi_tb;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic line_fault_i = 1'b0;
    logic aux_fault_i = 1'b0;
    logic line_hi_o, line_lo_o, aux_hi_o, aux_lo_o, serial_mode_o;
    logic [4:0] drv;
    logic [7:0] st, rd;
    logic [31:0] d;
    int err_total = 0;
    int tests_run = 0;
    // Pins, expected {serial, line hi/lo, aux hi/lo}
    logic [11:0] pin_tab [4] = '{{7'h2e, 5'h06}, {7'h1a, 5'h08},
        {7'h4e, 5'h04}, {7'h54, 5'h00}};
    // Command, config byte, pins, expected drive
    logic [27:0] ser_tab [10] = '{{8'h84, 8'h06, 7'h01, 5'h18},
        {8'h84, 8'h02, 7'h07, 5'h14}, {8'h84, 8'h01, 7'h03, 5'h18},
        {8'h84, 8'h07, 7'h03, 5'h10}, {8'h84, 8'h00, 7'h01, 5'h10},
        {8'h84, 8'h00, 7'h07, 5'h14}, {8'h85, 8'h05, 7'h19, 5'h12},
        {8'h85, 8'h00, 7'h19, 5'h11}, {8'h85, 8'h03, 7'h19, 5'h10},
        {8'h85, 8'h0b, 7'h0f, 5'h15}};
    assign drv = {serial_mode_o, line_hi_o, line_lo_o, aux_hi_o, aux_lo_o};
    always #5 ref_clk_i = ~ref_clk_i;
    ddc_link_if i_ddc_link_if ();
    ddc_host i_ddc_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(i_ddc_link_if));
    ddc_device i_ddc_device (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .link(i_ddc_link_if), .line_fault_i(line_fault_i),
        .aux_fault_i(aux_fault_i), .line_hi_o(line_hi_o),
        .line_lo_o(line_lo_o), .aux_hi_o(aux_hi_o), .aux_lo_o(aux_lo_o),
        .serial_mode_o(serial_mode_o));
    ddc_link_properties i_ddc_link_properties (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .mode_sel(i_ddc_link_if.mode_sel),
        .csn_pp(i_ddc_link_if.csn_pp), .sdi_sink(i_ddc_link_if.sdi_sink),
        .sck(i_ddc_link_if.sck), .sdo(i_ddc_link_if.sdo),
        .sdo_oe_n(i_ddc_link_if.sdo_oe_n));
    // ------------
    // Bus tasks
    // ------------
    task wb(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Fixed wait covers pin sync plus driver latency
    task pins(input logic [6:0] p);
        wb(1'b1, ddc_pkg::WB_PINS, {25'h0, p});
        repeat (6) @(posedge ref_clk_i);
    endtask
    task xfer(input logic [7:0] cmd, input logic [7:0] wd);
        wb(1'b1, ddc_pkg::WB_CMD, {16'h0, wd, cmd});
        d = 32'h1;
        while (d[0] !== 1'b0) wb(1'b0, ddc_pkg::WB_STAT, 32'h0);
        st = d[23:16];
        rd = d[15:8];
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #500000;
        err_total++;
        summarize();
    end
    // ------------
    // Tests
    // ------------
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        foreach (pin_tab[i]) begin
            pins(pin_tab[i][11:5]);
            `CHK("pin drive", pin_tab[i][4:0], drv)
        end
        $display("pin mode test done");
        pins(7'h01);
        `CHK("serial mode", 5'h10, drv)
        xfer(8'h01, 8'h00);
        `CHK("status byte", 8'h04, st)
        `CHK("status data", 8'h04, rd)
        xfer(8'h04, 8'h00);
        `CHK("line cfg", 8'h03, rd)
        xfer(8'h10, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        $display("serial read test done");
        foreach (ser_tab[i]) begin
            pins(7'h01);
            xfer(ser_tab[i][27:20], ser_tab[i][19:12]);
            pins(ser_tab[i][11:5]);
            `CHK("serial drive", ser_tab[i][4:0], drv)
        end
        $display("serial drive test done");
        xfer(8'h01, 8'h00);
        `CHK("track status", 8'h0c, st)
        line_fault_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        `CHK("fault off", 5'h10, drv)
        xfer(8'h00, 8'h00);
        `CHK("fault status", 8'h0d, st)
        `CHK("int set", 8'h01, rd)
        line_fault_i <= 1'b0;
        xfer(8'h00, 8'h00);
        `CHK("int sticky", 8'h01, rd)
        xfer(8'h00, 8'h00);
        `CHK("int cleared", 8'h00, rd)
        aux_fault_i <= 1'b1;
        xfer(8'h01, 8'h00);
        `CHK("aux fault status", 8'h0e, st)
        `CHK("aux fault off", 5'h10, drv)
        // Tracking bit still set: pin mode must not honour it
        pins(7'h22);
        `CHK("pin no track", 5'h08, drv)
        `CHK("fault pin", 1'b0, i_ddc_link_if.sdo_line)
        wb(1'b0, ddc_pkg::WB_PINS, 32'h0);
        `CHK("pins read", 32'h22, d)
        $display("tracking fault test done");
        summarize();
    end
endmodule
